/* File: hdl/tcc_pkg.sv */
package tcc_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] ADDR_COUNT = 8'h00;
    localparam logic [7:0] ADDR_RELOAD = 8'h04;
    localparam logic [7:0] ADDR_CAPTURE = 8'h08;
    localparam logic [7:0] ADDR_CTL0 = 8'h0c;
    localparam logic [7:0] ADDR_CTL1 = 8'h10;

    // First control register fields
    localparam int CTL0_MODE_MSB_BIT = 7;
    localparam int CTL0_SRC_HI_BIT = 6;
    localparam int CTL0_SRC_LO_BIT = 5;
    localparam int CTL0_OUT_EN_BIT = 1;
    localparam int CTL0_CAUSE_BIT = 0;
    localparam logic [7:0] CTL0_WR_MASK = 8'he2;

    // Second control register fields
    localparam int CTL1_EN_BIT = 7;
    localparam int CTL1_POL_BIT = 6;
    localparam int CTL1_PRE_HI_BIT = 5;
    localparam int CTL1_PRE_LO_BIT = 3;
    localparam int CTL1_MODE_HI_BIT = 2;
    localparam int CTL1_MODE_LO_BIT = 0;

    // Reset and restart values
    localparam logic [15:0] COUNT_RST = 16'h0001;
    localparam logic [15:0] RELOAD_RST = 16'hffff;
    localparam logic [15:0] CAPTURE_RST = 16'h0000;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [15:0] RESTART_VALUE = 16'h0001;

    // Prescaler counter width, enough for divide by 128
    localparam int PRE_CNT_W = 7;

    typedef logic [3:0] tcc_mode_type;

    localparam tcc_mode_type MODE_COMPARE = 4'h5;
    localparam tcc_mode_type MODE_GATED = 4'h6;
    localparam tcc_mode_type MODE_CAPCMP = 4'h7;
    localparam tcc_mode_type MODE_CAPRESTART = 4'h8;

    // Interrupt source selection codes
    localparam logic [1:0] SRC_INPUT_ONLY = 2'h2;
    localparam logic [1:0] SRC_RELOAD_ONLY = 2'h3;

    typedef enum logic {CC_WAIT, CC_RUN} tcc_cc_state_type;

endpackage : tcc_pkg

/* File: hdl/tcc_if.sv */
interface tcc_if;
    logic tick;
    logic pre_en;
    logic [2:0] pre_sel;
    logic pin_raw;
    logic in_level;
    logic in_rise;
    logic in_fall;

    modport pre (input pre_en, input pre_sel, output tick);
    modport edg (input pin_raw, output in_level, output in_rise, output in_fall);
    modport core (output pre_en, output pre_sel, output pin_raw,
                  input tick, input in_level, input in_rise, input in_fall);
endinterface : tcc_if

/* File: hdl/tcc_prescaler.sv */
module tcc_prescaler (
    input wire logic clk,
    input wire logic rst,
    tcc_if.pre bus
);

    logic [tcc_pkg::PRE_CNT_W-1:0] cnt_ff;
    logic [tcc_pkg::PRE_CNT_W-1:0] last_val;

    // Divide by two to the power of the select value
    assign last_val = tcc_pkg::PRE_CNT_W'((8'h01 << bus.pre_sel) - 8'h01);
    assign bus.tick = bus.pre_en && (cnt_ff == last_val);

    always_ff @(posedge clk) begin
        if (rst || !bus.pre_en || bus.tick) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + tcc_pkg::PRE_CNT_W'(1);
        end
    end

endmodule : tcc_prescaler

/* File: hdl/tcc_edge.sv */
module tcc_edge (
    input wire logic clk,
    input wire logic rst,
    tcc_if.edg bus
);

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;

    // Two-stage synchroniser, then one stage for edge history
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            sync1_ff <= bus.pin_raw;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign bus.in_level = sync2_ff;
    assign bus.in_rise = sync2_ff && !prev_ff;
    assign bus.in_fall = !sync2_ff && prev_ff;

endmodule : tcc_edge

/* File: hdl/tcc_top.sv */
// Our own choices: register access over APB and the register addresses.
module tcc_top (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic TIMER_IN,
    output logic TIMER_OUT,
    output logic TIMER_IRQ
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == tcc_pkg::ADDR_COUNT) || (a == tcc_pkg::ADDR_RELOAD) ||
                  (a == tcc_pkg::ADDR_CAPTURE) || (a == tcc_pkg::ADDR_CTL0) ||
                  (a == tcc_pkg::ADDR_CTL1);
    endfunction : addr_ok

    function automatic logic irq_allowed(input logic [1:0] src, input logic is_input);
        case (src)
            tcc_pkg::SRC_INPUT_ONLY: irq_allowed = is_input;
            tcc_pkg::SRC_RELOAD_ONLY: irq_allowed = !is_input;
            default: irq_allowed = 1'b1;
        endcase
    endfunction : irq_allowed

    ////////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [15:0] count_ff;
    logic [15:0] reload_ff;
    logic [15:0] capture_ff;
    logic [7:0] ctl0_ff;
    logic [7:0] ctl1_ff;
    logic cause_ff;
    logic out_ff;
    logic irq_ff;
    logic [31:0] prdata_ff;
    tcc_pkg::tcc_cc_state_type cc_state_ff;
    tcc_pkg::tcc_cc_state_type nxt_cc_state;

    ////////////////////////////////////////////////////////////////////////////////
    // Sub-blocks

    tcc_if tbus ();

    tcc_prescaler u_pre (
        .clk(SYS_CLK),
        .rst(RESET),
        .bus(tbus.pre)
    );

    tcc_edge u_edge (
        .clk(SYS_CLK),
        .rst(RESET),
        .bus(tbus.edg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Control decode

    tcc_pkg::tcc_mode_type mode;
    logic enabled;
    logic pol;
    logic out_en;
    logic [1:0] src_sel;
    logic is_cr;
    logic is_cmp;
    logic is_gated;
    logic is_cc;

    assign mode = {ctl0_ff[tcc_pkg::CTL0_MODE_MSB_BIT],
                   ctl1_ff[tcc_pkg::CTL1_MODE_HI_BIT:tcc_pkg::CTL1_MODE_LO_BIT]};
    assign enabled = ctl1_ff[tcc_pkg::CTL1_EN_BIT];
    assign pol = ctl1_ff[tcc_pkg::CTL1_POL_BIT];
    assign out_en = ctl0_ff[tcc_pkg::CTL0_OUT_EN_BIT];
    assign src_sel = ctl0_ff[tcc_pkg::CTL0_SRC_HI_BIT:tcc_pkg::CTL0_SRC_LO_BIT];
    assign is_cr = (mode == tcc_pkg::MODE_CAPRESTART);
    assign is_cmp = (mode == tcc_pkg::MODE_COMPARE);
    assign is_gated = (mode == tcc_pkg::MODE_GATED);
    assign is_cc = (mode == tcc_pkg::MODE_CAPCMP);

    assign tbus.pre_en = enabled;
    assign tbus.pre_sel = ctl1_ff[tcc_pkg::CTL1_PRE_HI_BIT:tcc_pkg::CTL1_PRE_LO_BIT];
    assign tbus.pin_raw = TIMER_IN;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic access;
    logic wr;
    logic wr_count;
    logic wr_reload;
    logic wr_capture;
    logic wr_ctl0;
    logic wr_ctl1;
    logic [31:0] rd_data;

    assign access = PSEL && PENABLE;
    assign wr = access && PWRITE && addr_ok(PADDR);
    assign wr_count = wr && (PADDR == tcc_pkg::ADDR_COUNT);
    assign wr_reload = wr && (PADDR == tcc_pkg::ADDR_RELOAD);
    assign wr_capture = wr && (PADDR == tcc_pkg::ADDR_CAPTURE);
    assign wr_ctl0 = wr && (PADDR == tcc_pkg::ADDR_CTL0);
    assign wr_ctl1 = wr && (PADDR == tcc_pkg::ADDR_CTL1);
    assign PREADY = 1'b1;
    assign PSLVERR = access && !addr_ok(PADDR);
    assign PRDATA = prdata_ff;

    always_comb begin
        case (PADDR)
            tcc_pkg::ADDR_COUNT: rd_data = {16'h0000, count_ff};
            tcc_pkg::ADDR_RELOAD: rd_data = {16'h0000, reload_ff};
            tcc_pkg::ADDR_CAPTURE: rd_data = {16'h0000, capture_ff};
            tcc_pkg::ADDR_CTL0: rd_data = {24'h000000, ctl0_ff[7:1], cause_ff};
            tcc_pkg::ADDR_CTL1: rd_data = {24'h000000, ctl1_ff};
            default: rd_data = 32'h00000000;
        endcase
    end

    // Read data is fetched in the setup cycle and shown in the access cycle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            prdata_ff <= 32'h00000000;
        end else if (PSEL && !PENABLE) begin
            prdata_ff <= rd_data;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctl0_ff <= tcc_pkg::CTL_RST;
            ctl1_ff <= tcc_pkg::CTL_RST;
            reload_ff <= tcc_pkg::RELOAD_RST;
        end else begin
            if (wr_ctl0) begin
                ctl0_ff <= PWDATA[7:0] & tcc_pkg::CTL0_WR_MASK;
            end
            if (wr_ctl1) begin
                ctl1_ff <= PWDATA[7:0];
            end
            if (wr_reload) begin
                reload_ff <= PWDATA[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Events

    logic sel_edge;
    logic deassert;
    logic active;
    logic cc_waiting;
    logic count_ok;
    logic hit;
    logic cap_evt;
    logic gate_off;
    logic reload_evt;
    logic input_evt;
    logic restart_mode;

    assign sel_edge = pol ? tbus.in_fall : tbus.in_rise;
    assign active = tbus.in_level ^ pol;
    assign deassert = pol ? tbus.in_rise : tbus.in_fall;
    assign cc_waiting = is_cc && (cc_state_ff == tcc_pkg::CC_WAIT);
    assign restart_mode = is_cr || is_gated || is_cc;

    // Ticks only: compare mode never counts the input pin
    assign count_ok = tbus.tick && !(is_gated && !active) && !cc_waiting;
    assign hit = count_ok && (count_ff == reload_ff);
    assign cap_evt = enabled && sel_edge && (is_cr || (is_cc && !cc_waiting));
    assign gate_off = enabled && is_gated && deassert;
    assign reload_evt = hit && (restart_mode || is_cmp) && !cap_evt;
    assign input_evt = cap_evt || gate_off;

    ////////////////////////////////////////////////////////////////////////////////
    // Capture/compare start state

    always_comb begin
        nxt_cc_state = cc_state_ff;
        case (cc_state_ff)
            tcc_pkg::CC_WAIT: begin
                if (enabled && is_cc && sel_edge) begin
                    nxt_cc_state = tcc_pkg::CC_RUN;
                end
            end
            tcc_pkg::CC_RUN: begin
                if (!enabled || !is_cc) begin
                    nxt_cc_state = tcc_pkg::CC_WAIT;
                end
            end
            default: nxt_cc_state = tcc_pkg::CC_WAIT;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cc_state_ff <= tcc_pkg::CC_WAIT;
        end else begin
            cc_state_ff <= nxt_cc_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            count_ff <= tcc_pkg::COUNT_RST;
        end else if (wr_count) begin
            count_ff <= PWDATA[15:0];
        end else if (cap_evt) begin
            count_ff <= tcc_pkg::RESTART_VALUE;
        end else if (hit && restart_mode) begin
            count_ff <= tcc_pkg::RESTART_VALUE;
        end else if (count_ok) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capture register and cause flag

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            capture_ff <= tcc_pkg::CAPTURE_RST;
        end else if (cap_evt) begin
            capture_ff <= count_ff;
        end else if (wr_capture) begin
            capture_ff <= PWDATA[15:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            cause_ff <= 1'b0;
        end else if (cap_evt) begin
            cause_ff <= 1'b1;
        end else if (reload_evt && (is_cr || is_cc)) begin
            cause_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timer output and interrupt

    // While disabled the output rests at the level set by polarity
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            out_ff <= 1'b0;
        end else if (!enabled) begin
            out_ff <= pol;
        end else if (reload_evt && out_en && (is_cmp || is_gated)) begin
            out_ff <= !out_ff;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (input_evt && irq_allowed(src_sel, 1'b1)) ||
                      (reload_evt && irq_allowed(src_sel, 1'b0));
        end
    end

    assign TIMER_OUT = out_ff;
    assign TIMER_IRQ = irq_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_capture_store;
        @(posedge SYS_CLK) disable iff (RESET)
        cap_evt |=> capture_ff == $past(count_ff);
    endproperty
    a_capture_store: assert property (p_capture_store)
        else $error("Capture register missed the count");

    property p_edge_select;
        @(posedge SYS_CLK) disable iff (RESET)
        (cap_evt && !pol) |-> (tbus.in_level && !$past(tbus.in_level));
    endproperty
    a_edge_select: assert property (p_edge_select)
        else $error("Capture on wrong edge");

    sequence s_cr_capture;
        is_cr && cap_evt && !wr_count && src_sel != tcc_pkg::SRC_RELOAD_ONLY;
    endsequence

    property p_cr_capture;
        @(posedge SYS_CLK) disable iff (RESET)
        s_cr_capture |=> (count_ff == tcc_pkg::RESTART_VALUE) && cause_ff && irq_ff;
    endproperty
    a_cr_capture: assert property (p_cr_capture)
        else $error("Capture restart did not restart");

    property p_cr_reload;
        @(posedge SYS_CLK) disable iff (RESET)
        (is_cr && reload_evt && !wr_count) |=>
            (count_ff == tcc_pkg::RESTART_VALUE) && !cause_ff;
    endproperty
    a_cr_reload: assert property (p_cr_reload)
        else $error("Reload did not restart or clear cause");

    property p_cmp_continue;
        @(posedge SYS_CLK) disable iff (RESET)
        (is_cmp && count_ok && !wr_count) |=> count_ff == $past(count_ff) + 16'h0001;
    endproperty
    a_cmp_continue: assert property (p_cmp_continue)
        else $error("Compare mode did not keep counting");

    property p_out_toggle;
        @(posedge SYS_CLK) disable iff (RESET)
        (enabled && reload_evt && out_en && (is_cmp || is_gated) && !wr_ctl1) |=>
            TIMER_OUT != $past(TIMER_OUT);
    endproperty
    a_out_toggle: assert property (p_out_toggle)
        else $error("Output did not toggle");

    property p_gated_hold;
        @(posedge SYS_CLK) disable iff (RESET)
        (is_gated && !active && !wr_count) |=> $stable(count_ff);
    endproperty
    a_gated_hold: assert property (p_gated_hold)
        else $error("Gated counter moved while inactive");

    sequence s_cc_first_edge;
        enabled && cc_waiting && sel_edge;
    endsequence

    property p_cc_start;
        @(posedge SYS_CLK) disable iff (RESET)
        s_cc_first_edge |=> (cc_state_ff == tcc_pkg::CC_RUN) && !irq_ff;
    endproperty
    a_cc_start: assert property (p_cc_start)
        else $error("First edge mishandled");

    property p_src_input_only;
        @(posedge SYS_CLK) disable iff (RESET)
        (src_sel == tcc_pkg::SRC_INPUT_ONLY && !input_evt) |=> !irq_ff;
    endproperty
    a_src_input_only: assert property (p_src_input_only)
        else $error("Interrupt from masked source");

    property p_gated_off_irq;
        @(posedge SYS_CLK) disable iff (RESET)
        (gate_off && src_sel != tcc_pkg::SRC_RELOAD_ONLY) |=> irq_ff;
    endproperty
    a_gated_off_irq: assert property (p_gated_off_irq)
        else $error("No interrupt on deassertion");

endmodule : tcc_top

/* File: tb/tcc_pin_model.sv */
module tcc_pin_model (
    input wire logic clk,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pin idles low until the bench asks for a level
    initial begin
        pin = 1'b0;
    end

    // Levels change just after a rising edge and hold until the next call, which may be only one clock later
    task set_level(input logic lvl);
        @(posedge clk);
        pin <= lvl;
    endtask : set_level

endmodule : tcc_pin_model

/* File: tb/tcc_top_tb.sv */
module tcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic SYS_CLK;
    logic RESET;
    logic PSEL;
    logic PENABLE;
    logic PWRITE;
    logic [7:0] PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic TIMER_IN;
    logic TIMER_OUT;
    logic TIMER_IRQ;
    int failures;
    int tests_run;

    tcc_top i_dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_IN(TIMER_IN),
        .TIMER_OUT(TIMER_OUT), .TIMER_IRQ(TIMER_IRQ));

    tcc_pin_model i_pin (.clk(SYS_CLK), .pin(TIMER_IN));

    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end

    ////////////////////////////////////////
    task test_done();
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One APB transfer, held until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rdat, output logic err);
        int n;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1) begin
            failures++;
            test_done();
        end
        rdat = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask : rd

    // Returns lim when no pulse was seen within lim cycles
    task wait_irq(input int lim, output int n);
        n = 0;
        while (n < lim) begin
            @(posedge SYS_CLK);
            if (TIMER_IRQ === 1'b1) break;
            n++;
        end
    endtask : wait_irq

    // Disabled set-up: mode, edge, prescale, values, cleared capture, then enable
    task cfg(input tcc_pkg::tcc_mode_type m, input logic [1:0] src, input logic pol,
             input logic [2:0] pre, input logic [15:0] cnt, input logic [15:0] rel);
        logic [7:0] c1;
        c1 = {1'b0, pol, pre, m[2:0]};
        wr(tcc_pkg::ADDR_CTL1, {24'h0, c1});
        wr(tcc_pkg::ADDR_CTL0, {24'h0, m[3], src, 5'h02});
        wr(tcc_pkg::ADDR_COUNT, {16'h0, cnt});
        wr(tcc_pkg::ADDR_RELOAD, {16'h0, rel});
        wr(tcc_pkg::ADDR_CAPTURE, 32'h0);
        wr(tcc_pkg::ADDR_CTL1, {24'h0, 1'b1, c1[6:0]});
    endtask : cfg

    ////////////////////////////////////////
    task t_regs();
        logic [31:0] d;
        logic e;
        rd(tcc_pkg::ADDR_COUNT, d);
        check("count reset", d, {16'h0, tcc_pkg::COUNT_RST});
        rd(tcc_pkg::ADDR_RELOAD, d);
        check("reload reset", d, {16'h0, tcc_pkg::RELOAD_RST});
        rd(tcc_pkg::ADDR_CTL1, d);
        check("ctl1 reset", d, 32'h0);
        wr(tcc_pkg::ADDR_CTL0, 32'hff);
        rd(tcc_pkg::ADDR_CTL0, d);
        check("ctl0 writable", d, {24'h0, tcc_pkg::CTL0_WR_MASK});
        wr(tcc_pkg::ADDR_CTL0, 32'h0);
        apb(1'b0, 8'h14, 32'h0, d, e);
        check("unmapped err", e, 1);
        check("unmapped data", d, 0);
    endtask : t_regs

    task t_caprestart();
        logic [31:0] d;
        logic [31:0] cap;
        int n;
        cfg(tcc_pkg::MODE_CAPRESTART, 2'b00, 1'b1, 3'h0, 16'h0001, 16'h0100);
        i_pin.set_level(1'b1);
        wait_irq(40, n);
        check("wrong edge", n, 40);
        i_pin.set_level(1'b0);
        wait_irq(12, n);
        check("capture irq", n < 12, 1);
        rd(tcc_pkg::ADDR_CTL0, d);
        check("cause set", d[tcc_pkg::CTL0_CAUSE_BIT], 1);
        rd(tcc_pkg::ADDR_CAPTURE, cap);
        check("captured", cap > 32'h20 && cap < 32'h40, 1);
        rd(tcc_pkg::ADDR_COUNT, d);
        check("restart", d < 32'h10, 1);
        wait_irq(300, n);
        check("reload irq", n < 300, 1);
        rd(tcc_pkg::ADDR_CTL0, d);
        check("cause clear", d[tcc_pkg::CTL0_CAUSE_BIT], 0);
        rd(tcc_pkg::ADDR_CAPTURE, d);
        check("capture kept", d, cap);
        rd(tcc_pkg::ADDR_COUNT, d);
        check("reload restart", d < 32'h10, 1);
    endtask : t_caprestart

    task t_compare();
        logic [31:0] d;
        logic o;
        int n;
        cfg(tcc_pkg::MODE_COMPARE, 2'b00, 1'b0, 3'h3, 16'h0000, 16'h0004);
        wait_irq(60, n);
        check("prescaled match", n >= 28 && n <= 50, 1);
        cfg(tcc_pkg::MODE_COMPARE, 2'b00, 1'b0, 3'h0, 16'hfff0, 16'hfff8);
        o = TIMER_OUT;
        i_pin.set_level(1'b1);
        wait_irq(30, n);
        check("compare irq", n < 30, 1);
        repeat (2) @(posedge SYS_CLK);
        check("out toggled", TIMER_OUT, !o);
        rd(tcc_pkg::ADDR_COUNT, d);
        check("no restart", d > 32'hfff8, 1);
        repeat (20) @(posedge SYS_CLK);
        rd(tcc_pkg::ADDR_COUNT, d);
        check("wrapped", d < 32'h40, 1);
        i_pin.set_level(1'b0);
    endtask : t_compare

    task t_gated();
        logic [31:0] d;
        logic [31:0] d2;
        logic o;
        int n;
        cfg(tcc_pkg::MODE_GATED, 2'b00, 1'b0, 3'h0, 16'h0050, 16'h0060);
        repeat (10) @(posedge SYS_CLK);
        rd(tcc_pkg::ADDR_COUNT, d);
        check("gated idle", d, 32'h50);
        o = TIMER_OUT;
        i_pin.set_level(1'b1);
        wait_irq(40, n);
        check("gated reload", n < 40, 1);
        repeat (2) @(posedge SYS_CLK);
        check("gated out", TIMER_OUT, !o);
        wait_irq(112, n);
        check("second pass", n > 80 && n < 112, 1);
        repeat (5) @(posedge SYS_CLK);
        i_pin.set_level(1'b0);
        wait_irq(8, n);
        check("deassert irq", n < 8, 1);
        rd(tcc_pkg::ADDR_COUNT, d);
        repeat (10) @(posedge SYS_CLK);
        rd(tcc_pkg::ADDR_COUNT, d2);
        check("gated hold", d2, d);
    endtask : t_gated

    task t_capcmp();
        logic [31:0] d;
        int n;
        cfg(tcc_pkg::MODE_CAPCMP, 2'b00, 1'b0, 3'h0, 16'h0001, 16'h0200);
        repeat (10) @(posedge SYS_CLK);
        rd(tcc_pkg::ADDR_COUNT, d);
        check("waits edge", d, 32'h1);
        i_pin.set_level(1'b1);
        wait_irq(12, n);
        check("first edge quiet", n, 12);
        rd(tcc_pkg::ADDR_COUNT, d);
        check("started", d > 32'h1, 1);
        i_pin.set_level(1'b0);
        i_pin.set_level(1'b1);
        wait_irq(12, n);
        check("capture irq", n < 12, 1);
        rd(tcc_pkg::ADDR_CTL0, d);
        check("cause set", d[tcc_pkg::CTL0_CAUSE_BIT], 1);
        rd(tcc_pkg::ADDR_CAPTURE, d);
        check("captured", d > 32'hc && d < 32'h30, 1);
        rd(tcc_pkg::ADDR_COUNT, d);
        check("restart", d < 32'h10, 1);
        wait_irq(544, n);
        check("compare irq", n < 544, 1);
        rd(tcc_pkg::ADDR_CTL0, d);
        check("cause clear", d[tcc_pkg::CTL0_CAUSE_BIT], 0);
        i_pin.set_level(1'b0);
    endtask : t_capcmp

    // Falling polarity: a low pin is the active level
    task t_gated_low();
        int n;
        cfg(tcc_pkg::MODE_GATED, 2'b00, 1'b1, 3'h0, 16'h0001, 16'h0010);
        wait_irq(24, n);
        check("low active reload", n < 24, 1);
        i_pin.set_level(1'b1);
        wait_irq(8, n);
        check("high deassert irq", n < 8, 1);
        i_pin.set_level(1'b0);
    endtask : t_gated_low

    // Reset in mid-run, bus traffic from the first edge after release
    task t_reset();
        logic [31:0] d;
        cfg(tcc_pkg::MODE_COMPARE, 2'b00, 1'b1, 3'h0, 16'h0100, 16'h0200);
        repeat (4) @(posedge SYS_CLK);
        check("pre-reset out", TIMER_OUT, 1);
        RESET <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        RESET <= 1'b0;
        check("reset out", TIMER_OUT, 0);
        check("reset irq", TIMER_IRQ, 0);
        rd(tcc_pkg::ADDR_COUNT, d);
        check("count after reset", d, {16'h0, tcc_pkg::COUNT_RST});
        rd(tcc_pkg::ADDR_CTL1, d);
        check("ctl1 after reset", d, 32'h0);
        rd(tcc_pkg::ADDR_RELOAD, d);
        check("reload after reset", d, {16'h0, tcc_pkg::RELOAD_RST});
        rd(tcc_pkg::ADDR_CAPTURE, d);
        check("capture after reset", d, {16'h0, tcc_pkg::CAPTURE_RST});
    endtask : t_reset

    task t_source();
        int n;
        for (int s = 0; s < 4; s++) begin
            cfg(tcc_pkg::MODE_CAPRESTART, s[1:0], 1'b0, 3'h0, 16'h0001, 16'h0040);
            wait_irq(80, n);
            check("reload event", n < 80, s != 2);
            i_pin.set_level(1'b1);
            wait_irq(8, n);
            check("input event", n < 8, s != 3);
            i_pin.set_level(1'b0);
        end
    endtask : t_source

    ////////////////////////////////////////
    initial begin
        failures = 0;
        tests_run = 0;
        RESET = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        repeat (20) @(posedge SYS_CLK);
        RESET <= 1'b0;
        t_regs();
        t_caprestart();
        t_compare();
        t_gated();
        t_capcmp();
        t_gated_low();
        t_source();
        t_reset();
        test_done();
    end

endmodule : tcc_top_tb
